// [scrb_pkg.sv]
/*
 * Shared definitions of the serial control register bank: addresses,
 * field layouts, reset values, transfer phases and carrier structs.
 * Assumes it is compiled before every design file that names it.
 */
package scrb_pkg;

   // ***************************************************************
   // Addresses
   // ***************************************************************
   localparam logic [7:0] ADDR_RESET_CMD  = 8'h01;
   localparam logic [7:0] ADDR_POWER      = 8'h02;
   localparam logic [7:0] ADDR_PHASE      = 8'h03;
   localparam logic [7:0] ADDR_WR_LAST    = 8'h08;
   localparam logic [7:0] ADDR_POWER_RB   = 8'hf2;
   localparam logic [7:0] ADDR_PHASE_RB   = 8'hf3;
   localparam logic [7:0] ADDR_RD_FIRST   = 8'hf2;
   localparam logic [7:0] ADDR_RD_LAST    = 8'hf8;

   // ***************************************************************
   // Fields and reset values
   // ***************************************************************
   localparam int          PHASE_CODE_LSB  = 3;
   localparam int          PHASE_CODE_W    = 5;
   localparam logic [15:0] PHASE_STEP_CDEG = 16'h0465;
   localparam logic [7:0]  POWER_RESET     = 8'h00;
   localparam logic [7:0]  PHASE_RESET     = 8'h00;
   localparam logic [2:0]  BIT_LAST        = 3'h7;

   // Power control layout, bit 7 down to bit 0.
   typedef struct packed {
      logic forwardPathEnable;
      logic feedbackPathEnable;
      logic biasRefEnable;
      logic filterAmpEnable;
      logic inputAmpEnable;
      logic errorAmpEnable;
      logic openLoopMode;
      logic errorAmpGainReduce;
   } scrb_power_s;

   // Loop phase layout: code in bits 7 to 3, reserved bits below.
   typedef struct packed {
      logic [PHASE_CODE_W-1:0]  code;
      logic [PHASE_CODE_LSB-1:0] reserved;
   } scrb_phase_s;

   // Serial pins after synchronisation.
   typedef struct packed {
      logic hwResetN;
      logic chipSelN;
      logic serialClk;
      logic serialDataIn;
   } scrb_pins_s;

   localparam logic [3:0] PINS_IDLE = 4'hc;

   typedef enum logic [2:0] {
      XFER_IDLE  = 3'b000,
      XFER_ADDR  = 3'b001,
      XFER_WRITE = 3'b010,
      XFER_READ  = 3'b011,
      XFER_SKIP  = 3'b100
   } scrb_xfer_e;

endpackage

// [scrb_sync.sv]
/*
 * Two-stage synchroniser for a group of pins.
 * Assumes the inputs are asynchronous to sys_clk; only the second
 * stage is visible to the logic outside.
 */
`timescale 1ns/100ps
module scrb_sync #(
   parameter int               WIDTH     = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire  logic             sys_clk,
   input  wire  logic             sys_rst,
   input  wire  logic [WIDTH-1:0] asyncIn,
   output logic       [WIDTH-1:0] syncOut
);

   initial begin
      if (WIDTH < 1) begin
         $error("scrb_sync needs WIDTH of at least 1.");
      end
   end

   typedef struct packed {
      logic [WIDTH-1:0] stage2;
      logic [WIDTH-1:0] stage1;
   } scrb_sync_s;

   scrb_sync_s state_q;
   scrb_sync_s state_d;

   always_comb begin
      state_d        = state_q;
      state_d.stage1 = asyncIn;
      state_d.stage2 = state_q.stage1;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q <= {RESET_VAL, RESET_VAL};
      end else begin
         state_q <= state_d;
      end
   end

   assign syncOut = state_q.stage2;

endmodule

// [scrb_serial_regs.sv]
/*
 * Serial control register bank: slave side of the serial control bus
 * with the reset command, power control and loop phase registers and
 * their read-back mirrors.
 * Assumes sys_clk at 200 MHz, well above four times the serial clock,
 * and pins asynchronous to it. sys_rst is the power-on reset.
 */
// Summary of operation
// R1 - One address byte, then optional data bytes.
// R2 - Data bit sampled on serial clock rise.
// R3 - Addresses 01-08 and F2-F8 are recognised.
// R4 - Address 01 alone clears every register.
// R5 - After reset all sections powered down.
// R6 - Power-on reset equals the reset command.
// R7 - Reset pin equals the reset command.
// R8 - Eight-bit power control at 02, reset zero.
// R9 - Bits 7-2 each enable one section.
// R10 - Shared oscillator on if bit 7 or 6.
// R11 - Bit 1 selects open-loop operation.
// R12 - Bit 0 reduces error amplifier gain.
// R13 - Eight-bit phase register at 03, reset zero.
// R14 - Bits 7-3 give code times 11.25 degrees.
// R15 - Host writes zero to phase bits 2-0.
// R16 - F2 and F3 read back both registers.
// R17 - Contents kept while supplies stay up.
// R18 - MSB first, framed by active-low chip select.
// R19 - Mirror data shifted out after address, MSB first.
// R20 - Writes to other addresses are ignored.
`timescale 1ns/100ps
module scrb_serial_regs (
   input  wire  logic                    sys_clk,
   input  wire  logic                    sys_rst,
   input  wire  logic                    hwResetN,
   input  wire  logic                    chipSelN,
   input  wire  logic                    serialClk,
   input  wire  logic                    serialDataIn,
   output logic                          serialDataOut,
   output logic                          serialDataOutEn,
   output scrb_pkg::scrb_power_s         powerCtl,
   output logic                          sharedLoEnable,
   output logic [scrb_pkg::PHASE_CODE_W-1:0] phaseCode,
   output logic [15:0]                   phaseCentiDeg
);

   // ***************************************************************
   // Pin synchronisation
   // ***************************************************************
   scrb_pkg::scrb_pins_s pins;

   scrb_sync #(
      .WIDTH     (4),
      .RESET_VAL (scrb_pkg::PINS_IDLE)
   ) u_pin_sync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .asyncIn ({hwResetN, chipSelN, serialClk, serialDataIn}),
      .syncOut (pins)
   );

   // ***************************************************************
   // Address decoding
   // ***************************************************************
   function automatic logic isMirror(input logic [7:0] addr);
      isMirror = (addr >= scrb_pkg::ADDR_RD_FIRST) && (addr <= scrb_pkg::ADDR_RD_LAST);
   endfunction

   function automatic logic isKnown(input logic [7:0] addr);
      isKnown = ((addr >= scrb_pkg::ADDR_RESET_CMD) && (addr <= scrb_pkg::ADDR_WR_LAST))
                || isMirror(addr);
   endfunction

   // Mirrors of the other register groups live elsewhere and read as zero here.
   function automatic logic [7:0] readBack(input logic [7:0] addr,
                                           input logic [7:0] power,
                                           input logic [7:0] phase);
      if (addr == scrb_pkg::ADDR_POWER_RB) begin
         readBack = power;
      end else if (addr == scrb_pkg::ADDR_PHASE_RB) begin
         readBack = phase;
      end else begin
         readBack = 8'h00;
      end
   endfunction

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      scrb_pkg::scrb_xfer_e  xfer;
      logic [2:0]            bitCnt;
      logic [7:0]            shiftIn;
      logic [7:0]            addr;
      scrb_pkg::scrb_power_s power;
      scrb_pkg::scrb_phase_s phase;
      logic                  loEnable;
      logic [15:0]           phaseCdeg;
      logic [7:0]            shiftOut;
      logic                  serial_data_out;
      logic                  sdoEn;
      logic                  sckPrev;
   } scrb_state_s;

   localparam scrb_state_s STATE_RESET = '{
      xfer:      scrb_pkg::XFER_IDLE,
      bitCnt:    3'h0,
      shiftIn:   8'h00,
      addr:      8'h00,
      power:     scrb_pkg::POWER_RESET,
      phase:     scrb_pkg::PHASE_RESET,
      loEnable:  1'b0,
      phaseCdeg: 16'h0000,
      shiftOut:  8'h00,
      serial_data_out:       1'b0,
      sdoEn:     1'b0,
      sckPrev:   1'b0
   };

   scrb_state_s state_q;
   scrb_state_s state_d;

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      logic                 sckRise;
      logic                 sckFall;
      logic [7:0]           byteIn;
      scrb_pkg::scrb_xfer_e cur;

      state_d = state_q;
      sckRise = pins.serialClk & ~state_q.sckPrev;
      sckFall = ~pins.serialClk & state_q.sckPrev;
      byteIn  = {state_q.shiftIn[6:0], pins.serialDataIn};
      cur     = (state_q.xfer == scrb_pkg::XFER_IDLE) ? scrb_pkg::XFER_ADDR : state_q.xfer;
      state_d.sckPrev = pins.serialClk;

      if (!pins.hwResetN) begin
         // The pin also aborts any transfer in flight.
         state_d.power  = scrb_pkg::POWER_RESET;                     // [R7] [R5]
         state_d.phase  = scrb_pkg::PHASE_RESET;                     // [R7]
         state_d.xfer   = scrb_pkg::XFER_IDLE;
         state_d.bitCnt = 3'h0;
         state_d.serial_data_out    = 1'b0;
         state_d.sdoEn  = 1'b0;
      end else if (pins.chipSelN) begin
         // Chip select high ends the frame; a partial byte is dropped.
         state_d.xfer   = scrb_pkg::XFER_IDLE;                       // [R18]
         state_d.bitCnt = 3'h0;
         state_d.serial_data_out    = 1'b0;
         state_d.sdoEn  = 1'b0;
      end else begin
         state_d.xfer = cur;
         if (sckRise) begin
            state_d.shiftIn = byteIn;                                // [R2] [R18]
            state_d.bitCnt  = state_q.bitCnt + 3'h1;
            if (state_q.bitCnt == scrb_pkg::BIT_LAST) begin
               case (cur)
                  scrb_pkg::XFER_ADDR: begin
                     state_d.addr = byteIn;                          // [R1]
                     if (byteIn == scrb_pkg::ADDR_RESET_CMD) begin
                        state_d.power = scrb_pkg::POWER_RESET;       // [R4] [R5] [R8]
                        state_d.phase = scrb_pkg::PHASE_RESET;       // [R4] [R13]
                        state_d.xfer  = scrb_pkg::XFER_SKIP;
                     end else if ((byteIn == scrb_pkg::ADDR_POWER) ||
                                  (byteIn == scrb_pkg::ADDR_PHASE)) begin
                        state_d.xfer = scrb_pkg::XFER_WRITE;
                     end else if (isMirror(byteIn)) begin
                        state_d.xfer     = scrb_pkg::XFER_READ;      // [R3] [R19]
                        state_d.shiftOut = readBack(byteIn, state_q.power,
                                                    state_q.phase);  // [R16]
                        state_d.sdoEn    = 1'b1;
                     end else begin
                        // Known addresses of other groups and unknown ones
                        // alike are swallowed to the end of the frame.
                        state_d.xfer = isKnown(byteIn) ? scrb_pkg::XFER_SKIP
                                                       : scrb_pkg::XFER_SKIP; // [R3] [R20]
                     end
                  end
                  scrb_pkg::XFER_WRITE: begin
                     // Every further data byte overwrites; the last one wins.
                     if (state_q.addr == scrb_pkg::ADDR_POWER) begin
                        state_d.power = byteIn;                      // [R1] [R8] [R9]
                     end else begin
                        state_d.phase = byteIn;                      // [R13] [R15]
                     end
                  end
                  default: begin
                     // Data to read-only or unknown addresses changes nothing.
                     state_d.xfer = cur;                             // [R20]
                  end
               endcase
            end
         end
         // Output bits change on the falling edge so the host can take
         // them on the next rise; zeros follow once the byte is out.
         if (sckFall && (cur == scrb_pkg::XFER_READ)) begin
            state_d.serial_data_out      = state_q.shiftOut[7];                  // [R19]
            state_d.shiftOut = {state_q.shiftOut[6:0], 1'b0};
         end
      end

      state_d.loEnable  = state_d.power.forwardPathEnable |
                          state_d.power.feedbackPathEnable;          // [R10]
      state_d.phaseCdeg = 16'(state_d.phase.code) * scrb_pkg::PHASE_STEP_CDEG; // [R14]
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   // Registers change only by write or reset, so contents hold while
   // this logic stays powered.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q <= STATE_RESET;                                     // [R6] [R5]
      end else begin
         state_q <= state_d;                                         // [R17]
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign serialDataOut   = state_q.serial_data_out;
   assign serialDataOutEn = state_q.sdoEn;
   assign powerCtl        = state_q.power;                           // [R9] [R11] [R12]
   assign sharedLoEnable  = state_q.loEnable;
   assign phaseCode       = state_q.phase.code;
   assign phaseCentiDeg   = state_q.phaseCdeg;

endmodule

// [scrb_serial_regs_properties.sv]
/*
 * Concurrent checks on the ports of the serial control register bank.
 * Assumes it is bound to scrb_serial_regs from the bench top file.
 */
`timescale 1ns/100ps
module scrb_serial_regs_properties (
   input wire logic                                 sys_clk,
   input wire logic                                 sys_rst,
   input wire logic                                 hwResetN,
   input wire logic                                 chipSelN,
   input wire logic                                 serialClk,
   input wire logic                                 serialDataIn,
   input wire logic                                 serialDataOut,
   input wire logic                                 serialDataOutEn,
   input wire scrb_pkg::scrb_power_s                powerCtl,
   input wire logic                                 sharedLoEnable,
   input wire logic [scrb_pkg::PHASE_CODE_W-1:0]    phaseCode,
   input wire logic [15:0]                          phaseCentiDeg
);
   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge sys_clk); endclocking

   chk_por_clears: assert property (sys_rst |=> powerCtl == '0 && phaseCode == '0
      && !serialDataOutEn) else $error("outputs not cleared by power-on reset");
   chk_pin_clears: assert property (disable iff (sys_rst) $fell(hwResetN) |-> ##[1:5]
      (powerCtl == '0 && phaseCode == '0)) else $error("reset pin did not clear");
   chk_lo_shared: assert property (disable iff (sys_rst) $stable(powerCtl) |->
      sharedLoEnable == (powerCtl.forwardPathEnable | powerCtl.feedbackPathEnable))
      else $error("shared oscillator enable wrong");
   chk_phase_scale: assert property (disable iff (sys_rst) $stable(phaseCode) |->
      phaseCentiDeg == {11'h000, phaseCode} * 16'h0465) else $error("phase angle wrong");
   chk_idle_hold: assert property (disable iff (sys_rst) (chipSelN && hwResetN) [*6] |->
      $stable(powerCtl) && $stable(phaseCode)) else $error("registers moved while idle");
   chk_out_framed: assert property (disable iff (sys_rst) $rose(serialDataOutEn) |->
      !chipSelN) else $error("output enabled outside a frame");
   chk_out_release: assert property (disable iff (sys_rst) chipSelN [*5] |->
      !serialDataOutEn) else $error("output still enabled after frame");
   chk_out_quiet: assert property (disable iff (sys_rst) !serialDataOutEn [*2] |->
      !serialDataOut) else $error("data out not low while idle");

   cover property ($rose(serialDataOutEn));
   cover property ($rose(sharedLoEnable));
   cover property ($fell(hwResetN));
endmodule

// [scrb_host_model.sv]
/*
 * Host model of the serial control bus: frames an address byte and
 * data bits and collects read-back bits.
 * Assumes one caller at a time; the link clock is made here, 48 ns.
 */
`timescale 1ns/100ps
module scrb_host_model (
   output logic      chipSelN,
   output logic      serialClk,
   output logic      serialDataIn,
   input  wire logic serialDataOut
);
   initial begin
      chipSelN     = 1'b1;
      serialClk    = 1'b0;
      serialDataIn = 1'b0;
   end

   // Address byte first, then data bits, MSB first inside chip select.
   task automatic frame(input logic [7:0] addr, input logic [15:0] data,
                        input int nBits, output logic [7:0] rdData);
      logic [23:0] shift;
      shift    = {addr, data};
      rdData   = 8'h00;
      chipSelN = 1'b0;
      #24;
      for (int i = 0; i < 8 + nBits; i++) begin
         serialDataIn = shift[23 - i];
         #24;
         serialClk = 1'b1;
         #23;
         // The device moves its output only after a fall, so sample late.
         if (i >= 8 && i < 16) rdData = {rdData[6:0], serialDataOut};
         #1;
         serialClk = 1'b0;
      end
      #24;
      chipSelN = 1'b1;
      // The line is not held between frames; flip it so stale data shows.
      serialDataIn = ~serialDataIn;
      #30;
   endtask
endmodule

// [scrb_serial_regs_test.sv]
/*
 * Self-checking bench of the serial control register bank.
 * Assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/100ps
module scrb_serial_regs_test;
   logic                                 sys_clk;
   logic                                 sys_rst;
   logic                                 hwResetN;
   logic                                 chipSelN;
   logic                                 serialClk;
   logic                                 serialDataIn;
   logic                                 serialDataOut;
   logic                                 serialDataOutEn;
   scrb_pkg::scrb_power_s                powerCtl;
   logic                                 sharedLoEnable;
   logic [scrb_pkg::PHASE_CODE_W-1:0]    phaseCode;
   logic [15:0]                          phaseCentiDeg;
   int                                   mismatches;
   int                                   compares;
   logic [7:0]                           rd;
   // Rows: address, data, power after, phase after. Phase data keeps reserved bits 0.
   logic [31:0] rows [0:8] = '{32'h02a5a500, 32'h02808000, 32'h02404000,
      32'h023f3f00, 32'h03f83ff8, 32'h03083f08, 32'h04ff3f08, 32'hf2ff3f08, 32'h99003f08};

   scrb_serial_regs scrb_serial_regs_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .hwResetN(hwResetN), .chipSelN(chipSelN), .serialClk(serialClk),
      .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
      .serialDataOutEn(serialDataOutEn), .powerCtl(powerCtl),
      .sharedLoEnable(sharedLoEnable), .phaseCode(phaseCode), .phaseCentiDeg(phaseCentiDeg));
   scrb_host_model scrb_host_model_inst (.chipSelN(chipSelN), .serialClk(serialClk),
      .serialDataIn(serialDataIn), .serialDataOut(serialDataOut));

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask

   task automatic wrap_up;
      if (mismatches == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic send(input logic [7:0] a, input logic [15:0] d, input int n);
      scrb_host_model_inst.frame(a, d, n, rd);
   endtask

   task automatic expect_state(input logic [7:0] p, input logic [7:0] q);
      chk("powerCtl", {8'h00, p}, {8'h00, powerCtl});
      chk("sharedLo", {15'h0000, p[7] | p[6]}, {15'h0000, sharedLoEnable});
      chk("phaseCode", {11'h000, q[7:3]}, {11'h000, phaseCode});
      chk("centiDeg", {11'h000, q[7:3]} * 16'h0465, phaseCentiDeg);
      send(8'hf2, 16'h0000, 8);
      chk("powerRb", {8'h00, p}, {8'h00, rd});
      send(8'hf3, 16'h0000, 8);
      chk("phaseRb", {8'h00, q}, {8'h00, rd});
   endtask

   // ***************************************************************
   // Sequence
   // ***************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial begin
      sys_rst    = 1'b1;
      hwResetN   = 1'b1;
      mismatches = 0;
      compares   = 0;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      expect_state(8'h00, 8'h00);
      foreach (rows[i]) begin
         send(rows[i][31:24], {rows[i][23:16], 8'h00}, 8);
         expect_state(rows[i][15:8], rows[i][7:0]);
      end
      // Two data bytes in one frame: the last one stays.
      send(8'h02, 16'h11c4, 16);
      expect_state(8'hc4, 8'h08);
      // A half byte at frame end is dropped.
      send(8'h03, 16'h5000, 4);
      expect_state(8'hc4, 8'h08);
      // Reset command with trailing data clears everything.
      send(8'h01, 16'hff00, 8);
      expect_state(8'h00, 8'h00);
      send(8'h02, 16'h8100, 8);
      send(8'h03, 16'h1800, 8);
      @(posedge sys_clk);
      hwResetN <= 1'b0;
      repeat (10) @(posedge sys_clk);
      hwResetN <= 1'b1;
      repeat (4) @(posedge sys_clk);
      expect_state(8'h00, 8'h00);
      send(8'h02, 16'hff00, 8);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      expect_state(8'h00, 8'h00);
      wrap_up();
   end

   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
endmodule

bind scrb_serial_regs scrb_serial_regs_properties scrb_serial_regs_properties_inst (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .hwResetN(hwResetN), .chipSelN(chipSelN),
   .serialClk(serialClk), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
   .serialDataOutEn(serialDataOutEn), .powerCtl(powerCtl), .sharedLoEnable(sharedLoEnable),
   .phaseCode(phaseCode), .phaseCentiDeg(phaseCentiDeg));
